//--- design/hf_ref_clock_switch_guard.sv
//------------------------------------------------------------------------------
// Purpose : oscillator enables, pin functions, hf reference switching and
//           system clock reset on forbidden settings, behind an APB slave
// Assumes : all inputs but i_sys_rst synchronous to i_clk; stop mode flag from mode control
// Notes   : sysclk reset is a level held while a forbidden setting stands
//------------------------------------------------------------------------------
// Overview of operation
// - hardware forces enables at reset release and on stop mode entry
// - all oscillators disabled raises the system clock reset
// - main clock on lf with lf oscillator off raises the reset
// - main clock on hf with its active source off raises the reset
// - external hf enabled while its pins are ports raises the reset
// - stopping the running source before a main clock switch ends resets
// - reference select 1 picks external hf, 0 picks internal oscillator
// - reset release clears the reference select to internal
// - switch to external completes within 2 internal plus 2.5 ext periods
// - reference pause during synchronisation stays within 2.5 periods
// - clearing internal enable within two machine cycles raises reset
// - reference select writes ignored while main clock runs on lf
// - rewriting 1 to an already set enable starts no warm-up
// - switch to internal completes within 2 ext plus 2.5 internal periods
// - clearing external hf enable during the guard raises reset
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module hf_ref_clock_switch_guard (
    input  wire logic                     i_clk,          // 100 MHz clock
    input  wire logic                     i_sys_rst,      // async, high
    input  wire clk_switch_pkg::apb_req_s i_apb,          // apb request
    input  wire logic                     i_stop_mode,    // stop mode active
    output var  clk_switch_pkg::apb_rsp_s o_apb,          // apb response
    output var  logic                     o_int_osc_en,   // run internal osc
    output var  logic                     o_ext_hf_osc_en,// run ext hf osc
    output var  logic                     o_ext_lf_osc_en,// run ext lf osc
    output var  logic                     o_hf_pins_xtal, // hf pins as crystal
    output var  logic                     o_lf_pins_xtal, // lf pins as crystal
    output var  logic                     o_main_is_lf,   // main clock on lf
    output var  logic                     o_ref_is_ext,   // reference is ext
    output var  logic                     o_ref_hold,     // reference paused
    output var  logic [2:0]               o_warmup_start, // start pulse per osc
    output var  logic                     o_sys_clk_rst   // system clock reset
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]                          sc1;
        logic [7:0]                          sc2;
        logic [7:0]                          pfc;
        logic [clk_switch_pkg::CAUSE_W-1:0]  cause;
        logic [clk_switch_pkg::CNT_W-1:0]    main_guard;
        logic                                sysck_q;
        clk_switch_pkg::apb_rsp_s            rsp;
        logic                                clk_rst;
        logic [2:0]                          osc_out;
        logic [1:0]                          pins;
        logic [2:0]                          warm;
    } guard_s;

    guard_s cur;
    guard_s next_cur;

    logic seq_ref_ext;
    logic seq_hold;
    logic seq_busy;
    logic seq_guard;

    // -------------------------------------------------------------------------
    // reference switch sequencer
    // -------------------------------------------------------------------------
    ref_switch_seq u_seq (
        .i_clk        (i_clk),
        .i_sys_rst    (i_sys_rst),
        .i_target     (cur.sc1[clk_switch_pkg::SC1_OSCSEL]),
        .o_ref_is_ext (seq_ref_ext),
        .o_ref_hold   (seq_hold),
        .o_busy       (seq_busy),
        .o_guard      (seq_guard)
    );

    // -------------------------------------------------------------------------
    // decoded control bits
    // -------------------------------------------------------------------------
    logic osc_en;
    logic xen;
    logic xten;
    logic sysck;
    logic oscsel;
    logic hf_pin;
    logic lf_pin;

    assign osc_en = cur.sc2[clk_switch_pkg::SC2_OSCEN];
    assign xen    = cur.sc2[clk_switch_pkg::SC2_XEN];
    assign xten   = cur.sc2[clk_switch_pkg::SC2_XTEN];
    assign sysck  = cur.sc2[clk_switch_pkg::SC2_SYSCK];
    assign oscsel = cur.sc1[clk_switch_pkg::SC1_OSCSEL];
    assign hf_pin = cur.pfc[clk_switch_pkg::PFC_HF];
    assign lf_pin = cur.pfc[clk_switch_pkg::PFC_LF];

    // -------------------------------------------------------------------------
    // forbidden combinations, checked only outside stop mode
    // -------------------------------------------------------------------------
    logic [clk_switch_pkg::CAUSE_W-1:0] fault;
    logic hf_src_off;
    logic leaving_off;

    // the active hf source is the one the sequencer currently uses
    assign hf_src_off  = seq_ref_ext ? ~xen : ~osc_en;
    // during the guard the source being left must stay enabled
    assign leaving_off = oscsel ? ~osc_en : ~xen;

    always_comb begin
        fault    = '0;
        fault[0] = ~osc_en & ~xen & ~xten;
        fault[1] = sysck & ~xten;
        fault[2] = ~sysck & hf_src_off;
        fault[3] = xen & ~hf_pin;
        fault[4] = (seq_guard & leaving_off)
                   | ((cur.main_guard != clk_switch_pkg::CNT_ZERO)
                      & (~xten | hf_src_off));
        if (i_stop_mode) begin
            fault = '0;
        end
    end

    // -------------------------------------------------------------------------
    // apb decode
    // -------------------------------------------------------------------------
    logic        setup;
    logic        commit;
    logic        hit_sc1;
    logic        hit_sc2;
    logic        hit_pfc;
    logic        hit_stat;
    logic [7:0]  stat;
    logic [7:0]  rd_byte;
    logic [7:0]  wbyte;

    assign setup  = i_apb.psel & ~i_apb.penable;
    assign commit = i_apb.psel & i_apb.penable & cur.rsp.pready;
    assign wbyte  = i_apb.pwdata[7:0];
    assign stat   = {cur.cause, seq_guard, seq_busy, seq_ref_ext};

    // address decode and read mux; reserved sc1 and sc2 bits read as zero
    always_comb begin
        hit_sc1  = 1'b0;
        hit_sc2  = 1'b0;
        hit_pfc  = 1'b0;
        hit_stat = 1'b0;
        rd_byte  = 8'h00;
        if (i_apb.paddr == clk_switch_pkg::SC1_ADDR) begin
            hit_sc1 = 1'b1;
            rd_byte = cur.sc1 & clk_switch_pkg::SC1_MASK;
        end else if (i_apb.paddr == clk_switch_pkg::SC2_ADDR) begin
            hit_sc2 = 1'b1;
            rd_byte = cur.sc2 & clk_switch_pkg::SC2_MASK;
        end else if (i_apb.paddr == clk_switch_pkg::PFC_ADDR) begin
            hit_pfc = 1'b1;
            rd_byte = cur.pfc;
        end else if (i_apb.paddr == clk_switch_pkg::STAT_ADDR) begin
            hit_stat = 1'b1;
            rd_byte  = stat;
        end
    end

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        logic [7:0]                         new_sc2;
        logic [clk_switch_pkg::CAUSE_W-1:0] clr;
        new_sc2  = cur.sc2;
        clr      = '0;
        next_cur = cur;

        // one wait state free answer: pready rises in the first access cycle
        next_cur.rsp.pready  = setup;
        next_cur.rsp.pslverr = setup & ~(hit_sc1 | hit_sc2 | hit_pfc | hit_stat);
        next_cur.rsp.prdata  = (setup & ~i_apb.pwrite) ? {24'h000000, rd_byte}
                                                       : 32'h00000000;

        // register writes take effect at the completing edge only
        if (commit & i_apb.pwrite) begin
            if (hit_sc1) begin
                next_cur.sc1 = wbyte & clk_switch_pkg::SC1_MASK;
                if (sysck) begin
                    // select is frozen while the main clock runs on lf
                    next_cur.sc1[clk_switch_pkg::SC1_OSCSEL] = oscsel;
                end
            end else if (hit_sc2) begin
                new_sc2      = wbyte & clk_switch_pkg::SC2_MASK;
                next_cur.sc2 = new_sc2;
            end else if (hit_pfc) begin
                next_cur.pfc = wbyte;
            end else if (hit_stat) begin
                clr = wbyte[7:clk_switch_pkg::STAT_CAUSE];
            end
        end

        // warm-up starts only on a real 0 to 1 change of an enable
        next_cur.warm[0] = new_sc2[clk_switch_pkg::SC2_OSCEN] & ~osc_en;
        next_cur.warm[1] = new_sc2[clk_switch_pkg::SC2_XEN] & ~xen;
        next_cur.warm[2] = new_sc2[clk_switch_pkg::SC2_XTEN] & ~xten;

        // main clock source change opens its own guard window
        next_cur.sysck_q = sysck;
        if (sysck != cur.sysck_q) begin
            next_cur.main_guard = 8'(clk_switch_pkg::GUARD_CYC);
        end else if (cur.main_guard != clk_switch_pkg::CNT_ZERO) begin
            next_cur.main_guard = cur.main_guard - clk_switch_pkg::CNT_ONE;
        end

        // sticky causes: a new fault wins over a clear in the same cycle
        next_cur.cause   = fault | (cur.cause & ~clr);
        next_cur.clk_rst = |fault;

        // pads follow the pin bits; oscillators stop in stop mode
        next_cur.pins    = {lf_pin, hf_pin};
        next_cur.osc_out = {xten & lf_pin & ~i_stop_mode,
                            xen & hf_pin & ~i_stop_mode,
                            osc_en & ~i_stop_mode};
    end

    // -------------------------------------------------------------------------
    // state register; reset values are the hardware-forced defaults
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cur            <= '0;
            cur.sc1        <= clk_switch_pkg::SC1_RESET;
            cur.sc2        <= clk_switch_pkg::SC2_RESET;
            cur.pfc        <= clk_switch_pkg::PFC_RESET;
            cur.osc_out    <= 3'h1;
        end else begin
            cur <= next_cur;
        end
    end

    // -------------------------------------------------------------------------
    // outputs, all from flip-flops but o_ref_hold, decoded from the sequencer state
    // -------------------------------------------------------------------------
    assign o_apb           = cur.rsp;
    assign o_int_osc_en    = cur.osc_out[0];
    assign o_ext_hf_osc_en = cur.osc_out[1];
    assign o_ext_lf_osc_en = cur.osc_out[2];
    assign o_hf_pins_xtal  = cur.pins[0];
    assign o_lf_pins_xtal  = cur.pins[1];
    assign o_main_is_lf    = cur.sysck_q;
    assign o_ref_is_ext    = seq_ref_ext;
    assign o_ref_hold      = seq_hold;
    assign o_warmup_start  = cur.warm;
    assign o_sys_clk_rst   = cur.clk_rst;

endmodule
`default_nettype wire

//--- design/clk_switch_pkg.sv
//------------------------------------------------------------------------------
// Purpose : shared constants and carriers for the hf reference clock guard
// Assumes : 100 MHz system clock, APB register access with 32-bit data
// Notes   : oscillator periods are plain defaults; adjust to the real parts
//------------------------------------------------------------------------------
package clk_switch_pkg;

    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;   // system clock period
    localparam int OSC_PERIOD_NS     = 200;  // internal hf oscillator period
    localparam int EXT_PERIOD_NS     = 125;  // ext_hf_clock period
    localparam int MACHINE_PERIOD_NS = 250;  // one machine cycle
    // longest switch time, in tenths of a nanosecond: 2/fosc + 2.5/fc and back
    localparam int TO_EXT_MAX_NS10 = 20 * OSC_PERIOD_NS + 25 * EXT_PERIOD_NS;
    localparam int TO_INT_MAX_NS10 = 20 * EXT_PERIOD_NS + 25 * OSC_PERIOD_NS;
    localparam int PAUSE_EXT_NS10  = 25 * EXT_PERIOD_NS;
    localparam int PAUSE_INT_NS10  = 25 * OSC_PERIOD_NS;
    // longest times round down, least times round up
    localparam int TO_EXT_CYC    = TO_EXT_MAX_NS10 / (10 * CLK_PERIOD_NS);
    localparam int TO_INT_CYC    = TO_INT_MAX_NS10 / (10 * CLK_PERIOD_NS);
    localparam int PAUSE_EXT_CYC = PAUSE_EXT_NS10 / (10 * CLK_PERIOD_NS);
    localparam int PAUSE_INT_CYC = PAUSE_INT_NS10 / (10 * CLK_PERIOD_NS);
    localparam int GUARD_MC      = 2;        // machine cycles of guard
    localparam int GUARD_CYC     =
        (GUARD_MC * MACHINE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 8;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

    // -------------------------------------------------------------------------
    // register map (index, byte address is four times the index)
    // -------------------------------------------------------------------------
    localparam logic [15:0] SC1_IDX   = 16'h0FDC;  // system_control_one
    localparam logic [15:0] SC2_IDX   = 16'h0FDD;  // system_control_two
    localparam logic [15:0] PFC_IDX   = 16'h0FD0;  // port_function_control
    localparam logic [15:0] STAT_IDX  = 16'h0FD1;  // guard status
    localparam logic [15:0] SC1_ADDR  = 16'(SC1_IDX * 4);
    localparam logic [15:0] SC2_ADDR  = 16'(SC2_IDX * 4);
    localparam logic [15:0] PFC_ADDR  = 16'(PFC_IDX * 4);
    localparam logic [15:0] STAT_ADDR = 16'(STAT_IDX * 4);

    // field layout and reset values
    localparam int          SC1_OSCSEL = 3;
    localparam logic [7:0]  SC1_MASK   = 8'hF8;
    localparam logic [7:0]  SC1_RESET  = 8'h00;
    localparam int          SC2_OSCEN  = 7;
    localparam int          SC2_XEN    = 6;
    localparam int          SC2_XTEN   = 5;
    localparam int          SC2_SYSCK  = 4;
    localparam logic [7:0]  SC2_MASK   = 8'hFC;
    localparam logic [7:0]  SC2_RESET  = 8'h80;
    localparam int          PFC_HF     = 0;    // hf_pin_function_bit
    localparam int          PFC_LF     = 2;    // lf_pin_function_bit
    localparam logic [7:0]  PFC_RESET  = 8'h00;
    localparam int          CAUSE_W    = 5;
    localparam int          STAT_CAUSE = 3;    // first cause bit in status

    // -------------------------------------------------------------------------
    // bus carriers
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [15:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_s;

endpackage

//--- design/ref_switch_seq.sv
//------------------------------------------------------------------------------
// Purpose : sequences the move of the hf reference between the two sources
// Assumes : both hf oscillators run while a switch is in progress
// Notes   : a select change during a switch is taken after it completes
//------------------------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module ref_switch_seq (
    input  wire logic i_clk,        // system clock
    input  wire logic i_sys_rst,    // async reset, active high
    input  wire logic i_target,     // requested reference, 1 = external
    output var  logic o_ref_is_ext, // current reference, 1 = external
    output var  logic o_ref_hold,   // reference paused while synchronising
    output var  logic o_busy,       // switch in progress
    output var  logic o_guard       // switch running or guard not yet over
);

    typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_PAUSE} sw_state_e;

    typedef struct packed {
        sw_state_e                      st;
        logic [clk_switch_pkg::CNT_W-1:0] cnt;
        logic [clk_switch_pkg::CNT_W-1:0] guard_cnt;
        logic                           target_q;
        logic                           ref_ext;
    } seq_s;

    seq_s cur;
    seq_s next_cur;

    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.target_q = i_target;
        // guard window restarts on every select change
        if (i_target != cur.target_q) begin
            next_cur.guard_cnt = 8'(clk_switch_pkg::GUARD_CYC);
        end else if (cur.guard_cnt != clk_switch_pkg::CNT_ZERO) begin
            next_cur.guard_cnt = cur.guard_cnt - clk_switch_pkg::CNT_ONE;
        end
        case (cur.st)
            ST_IDLE: begin
                // sync phase is the switch time less the trailing pause
                if (i_target != cur.ref_ext) begin
                    next_cur.st = ST_SYNC;
                    if (i_target) begin
                        next_cur.cnt = 8'(clk_switch_pkg::TO_EXT_CYC
                                       - clk_switch_pkg::PAUSE_EXT_CYC);
                    end else begin
                        next_cur.cnt = 8'(clk_switch_pkg::TO_INT_CYC
                                       - clk_switch_pkg::PAUSE_INT_CYC);
                    end
                end
            end
            ST_SYNC: begin
                if (cur.cnt <= clk_switch_pkg::CNT_ONE) begin
                    next_cur.st = ST_PAUSE;
                    if (cur.ref_ext) begin
                        next_cur.cnt = 8'(clk_switch_pkg::PAUSE_INT_CYC);
                    end else begin
                        next_cur.cnt = 8'(clk_switch_pkg::PAUSE_EXT_CYC);
                    end
                end else begin
                    next_cur.cnt = cur.cnt - clk_switch_pkg::CNT_ONE;
                end
            end
            ST_PAUSE: begin
                // reference flips at the end of the pause, never mid-pulse
                if (cur.cnt <= clk_switch_pkg::CNT_ONE) begin
                    next_cur.st      = ST_IDLE;
                    next_cur.ref_ext = ~cur.ref_ext;
                    next_cur.cnt     = clk_switch_pkg::CNT_ZERO;
                end else begin
                    next_cur.cnt = cur.cnt - clk_switch_pkg::CNT_ONE;
                end
            end
            default: begin
                next_cur.st = ST_IDLE;
            end
        endcase
    end

    // -------------------------------------------------------------------------
    // state register; reset picks the internal oscillator
    // -------------------------------------------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cur <= '{st: ST_IDLE, cnt: 8'h00, guard_cnt: 8'h00,
                     target_q: 1'b0, ref_ext: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign o_ref_is_ext = cur.ref_ext;
    assign o_ref_hold   = (cur.st == ST_PAUSE);
    assign o_busy       = (cur.st != ST_IDLE);
    assign o_guard      = (cur.st != ST_IDLE)
                          || (cur.guard_cnt != clk_switch_pkg::CNT_ZERO);

endmodule
`default_nettype wire

//--- dv/hf_ref_guard_sva.sv
// Purpose : port-level checks for the hf reference clock guard
// Assumes : one i_clk domain, i_sys_rst async and active high
// Notes   : bound to every instance of the guard below the module
`timescale 1ns/1ns
`default_nettype none
module hf_ref_guard_sva (
    input wire logic                     i_clk,           // system clock
    input wire logic                     i_sys_rst,       // async reset
    input wire logic                     i_stop_mode,     // stop mode flag
    input wire clk_switch_pkg::apb_req_s i_apb,           // apb request
    input wire clk_switch_pkg::apb_rsp_s o_apb,           // apb response
    input wire logic                     o_int_osc_en,    // internal osc run
    input wire logic                     o_ext_hf_osc_en, // ext hf osc run
    input wire logic                     o_ext_lf_osc_en, // ext lf osc run
    input wire logic                     o_hf_pins_xtal,  // hf pins as xtal
    input wire logic                     o_lf_pins_xtal,  // lf pins as xtal
    input wire logic                     o_main_is_lf,    // main clock on lf
    input wire logic                     o_ref_is_ext,    // reference is ext
    input wire logic                     o_ref_hold,      // reference paused
    input wire logic [2:0]               o_warmup_start,  // warm-up pulses
    input wire logic                     o_sys_clk_rst    // sysclk reset
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    logic [7:0] hold_cnt;  // length of the current reference pause
    logic       wr_sc1;    // select write that the block must honour
    assign wr_sc1 = i_apb.psel && i_apb.penable && o_apb.pready
        && i_apb.pwrite && !o_main_is_lf
        && i_apb.paddr == clk_switch_pkg::SC1_ADDR;
    // counter instead of a long repetition keeps the tools fast
    always_ff @(posedge i_clk or posedge i_sys_rst)
        if (i_sys_rst) hold_cnt <= 8'h00;
        else hold_cnt <= o_ref_hold ? hold_cnt + 8'h01 : 8'h00;
    AST_APB_READY: assert property (i_apb.psel && !i_apb.penable
        |=> o_apb.pready) else $error("no ready after setup");
    AST_HF_PINS: assert property (o_ext_hf_osc_en |-> o_hf_pins_xtal)
        else $error("ext hf oscillator runs on port pins");
    AST_STOP_OFF: assert property (i_stop_mode |=> !o_int_osc_en
        && !o_ext_hf_osc_en && !o_ext_lf_osc_en)
        else $error("oscillator left running in stop mode");
    AST_HOLD_MAX: assert property (hold_cnt <= 8'h32)
        else $error("reference pause too long");
    AST_HOLD_EXT: assert property (o_ref_hold && !o_ref_is_ext
        |-> hold_cnt < 8'h1F) else $error("pause to external too long");
    AST_LF_PINS: assert property (o_ext_lf_osc_en |-> o_lf_pins_xtal)
        else $error("ext lf oscillator runs on port pins");
    AST_TO_EXT: assert property (wr_sc1 && i_apb.pwdata[3]
        |-> ##[1:160] o_ref_is_ext) else $error("no switch to external");
    AST_TO_INT: assert property (wr_sc1 && !i_apb.pwdata[3]
        |-> ##[1:160] !o_ref_is_ext) else $error("no switch to internal");
    AST_WARM_INT: assert property (o_warmup_start[0] && !i_stop_mode
        |=> o_int_osc_en) else $error("warm-up without enable");
    AST_WARM_EXT: assert property (o_warmup_start[1]
        |-> !o_ext_hf_osc_en) else $error("warm-up on running osc");
    C_SWITCH: cover property ($rose(o_ref_is_ext));
    C_FAULT: cover property ($rose(o_sys_clk_rst));
    C_PAUSE: cover property ($fell(o_ref_hold));
endmodule
bind hf_ref_clock_switch_guard hf_ref_guard_sva u_sva (.i_clk, .i_sys_rst,
    .i_stop_mode, .i_apb, .o_apb, .o_int_osc_en, .o_ext_hf_osc_en,
    .o_ext_lf_osc_en, .o_hf_pins_xtal, .o_lf_pins_xtal, .o_main_is_lf,
    .o_ref_is_ext, .o_ref_hold, .o_warmup_start, .o_sys_clk_rst);
`default_nettype wire

//--- dv/hf_ref_clock_switch_guard_tb_top.sv
// Purpose : self-checking bench for the hf reference clock guard
// Assumes : status reads show causes; sysclk reset sampled with each read
// Notes   : reads leave notes in a queue that one monitor process checks
`timescale 1ns/1ns
`default_nettype none
module hf_ref_clock_switch_guard_tb_top;
    localparam logic [15:0] sc1_a = clk_switch_pkg::SC1_ADDR;
    localparam logic [15:0] sc2_a = clk_switch_pkg::SC2_ADDR;
    localparam logic [15:0] pfc_a = clk_switch_pkg::PFC_ADDR;
    localparam logic [15:0] st_a  = clk_switch_pkg::STAT_ADDR;
    localparam logic [33:0] full  = 34'h3_0000_00FF;
    logic i_clk = 1'b0, i_sys_rst = 1'b1, i_stop_mode = 1'b0;
    clk_switch_pkg::apb_req_s i_apb = '0;
    clk_switch_pkg::apb_rsp_s o_apb;
    logic o_int_osc_en, o_ext_hf_osc_en, o_ext_lf_osc_en, o_hf_pins_xtal;
    logic o_lf_pins_xtal, o_main_is_lf, o_ref_is_ext, o_ref_hold;
    logic o_sys_clk_rst;
    logic [2:0] o_warmup_start;
    logic [33:0] exp_q[$], msk_q[$], got_v, exp_v, msk_v; // {err,rst,data}
    logic [23:0] tbl[4] = '{24'h050008, 24'h059010, 24'h054020, 24'h00C040};
    int err_count = 0, samples_checked = 0, cyc = 0, seed = 80;
    logic [7:0] rnd;
    always #5 i_clk = ~i_clk;
    hf_ref_clock_switch_guard DUT (.i_clk, .i_sys_rst, .i_apb, .i_stop_mode,
        .o_apb, .o_int_osc_en, .o_ext_hf_osc_en, .o_ext_lf_osc_en,
        .o_hf_pins_xtal, .o_lf_pins_xtal, .o_main_is_lf, .o_ref_is_ext,
        .o_ref_hold, .o_warmup_start, .o_sys_clk_rst);
    task automatic end_sim();
        if (err_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // request stands until pready is sampled high, then is released
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
        @(posedge i_clk);
        i_apb <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge i_clk);
        i_apb.penable <= 1'b1;
        do @(posedge i_clk); while (o_apb.pready !== 1'b1);
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [33:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        xfer(1'b0, a, 8'h00);
    endtask
    // both oscillators run across the swap; leaving one stops after guard
    task automatic swap(input logic [7:0] sel, input logic [7:0] keep);
        xfer(1'b1, sc2_a, 8'hC0);
        xfer(1'b1, sc1_a, sel);
        repeat (100) @(posedge i_clk);
        xfer(1'b1, sc2_a, keep);
    endtask
    // hang guard: the whole run needs well under 5000 cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            end_sim();
        end
    end
    // monitor: each read answer takes the oldest note off the queue
    always @(posedge i_clk)
        if (i_apb.psel && i_apb.penable && o_apb.pready === 1'b1
            && !i_apb.pwrite && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            msk_v = msk_q.pop_front();
            got_v = {o_apb.pslverr, o_sys_clk_rst, o_apb.prdata} & msk_v;
            samples_checked++;
            if (got_v !== (exp_v & msk_v)) begin
                err_count++;
                $display("unexpected read at %h: expected %h, seen %h",
                         i_apb.paddr, exp_v & msk_v, got_v);
            end
        end
    initial begin
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(sc1_a, 34'h0, full);
        rd(sc2_a, 34'h80, full);
        rnd = 8'($random(seed));
        xfer(1'b1, pfc_a, rnd);
        rd(pfc_a, {26'h0, rnd}, full);
        xfer(1'b1, pfc_a, 8'h05);
        rd(16'h0000, 34'h2_0000_0000, full);
        swap(8'h08, 8'h40);
        rd(st_a, 34'h1, full);
        swap(8'h00, 8'h80);
        rd(st_a, 34'h0, full);
        xfer(1'b1, sc2_a, 8'hC0);
        xfer(1'b1, sc1_a, 8'h08);
        xfer(1'b1, sc2_a, 8'h40);
        rd(st_a, 34'h1_0000_0080, 34'h1_0000_0080);
        repeat (100) @(posedge i_clk);
        xfer(1'b1, st_a, 8'hF8);
        rd(st_a, 34'h1, full);
        swap(8'h00, 8'h80);
        xfer(1'b1, sc2_a, 8'hB0);
        xfer(1'b1, sc1_a, 8'h08);
        repeat (100) @(posedge i_clk);
        rd(sc1_a, 34'h0, 34'h1_0000_0008);
        xfer(1'b1, sc2_a, 8'hA0);
        repeat (60) @(posedge i_clk);
        xfer(1'b1, sc2_a, 8'h80);
        i_stop_mode <= 1'b1;
        repeat (4) @(posedge i_clk);
        i_stop_mode <= 1'b0;
        // each static forbidden setting in turn, then recover and clear causes
        foreach (tbl[i]) begin
            xfer(1'b1, pfc_a, tbl[i][23:16]);
            xfer(1'b1, sc2_a, tbl[i][15:8]);
            rd(st_a, {10'h100, tbl[i]}, {10'h100, 16'h0, tbl[i][7:0]});
            xfer(1'b1, sc2_a, 8'h80);
            xfer(1'b1, pfc_a, 8'h05);
            repeat (60) @(posedge i_clk);
            xfer(1'b1, st_a, 8'hF8);
            rd(st_a, 34'h0, full);
        end
        repeat (4) @(posedge i_clk);
        end_sim();
    end
endmodule
`default_nettype wire
